// ===== src/tea_pkg.sv
// Package: register map, field layout and types of the table/EEPROM access block
package tea_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_DATA     = 8'h04;
  localparam logic [7:0] OFF_ADDR_LOW = 8'h08;
  localparam logic [7:0] OFF_ADDR_HI  = 8'h0c;
  localparam logic [7:0] OFF_TBLPTR   = 8'h10;
  localparam logic [7:0] OFF_LATCH    = 8'h14;
  localparam logic [7:0] OFF_TBLCMD   = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
  // Control register field positions
  localparam int CTRL_RD     = 0;
  localparam int CTRL_WR     = 1;
  localparam int CTRL_PERMIT = 2;
  localparam int CTRL_FAULT  = 3;
  localparam int CTRL_REG_LO = 6;
  // Table command bits
  localparam int TCMD_FETCH  = 0;
  localparam int TCMD_STORE  = 1;
  // Region select codes
  localparam logic [1:0] REG_EEPROM  = 2'h0;
  localparam logic [1:0] REG_ID      = 2'h1;
  localparam logic [1:0] REG_PROGRAM = 2'h2;
  // Reset values
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] MASK_RESET  = 8'h00;
  // Default programming time in cycles (internal timer)
  localparam int PROG_CYCLES_DEF = 64;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Array-side request carried to the memories
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [1:0]  region;
    logic [21:0] addr;
    logic [7:0]  wdata;
  } tea_mem_req_t;

  typedef enum logic [1:0] { ST_IDLE, ST_READ, ST_WRITE } tea_state_t;
endpackage : tea_pkg

// ===== src/tea_top.sv
// Table read/write and data EEPROM access controller with AXI4-Lite slave
`timescale 1ns/1ps
module tea_top #(
  parameter int PROG_CYCLES = tea_pkg::PROG_CYCLES_DEF,
  parameter int HOLD_DEPTH  = 64
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output tea_pkg::tea_mem_req_t mem_req,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic [15:0] prog_word,
  output logic [21:0]      prog_addr,
  output logic             prog_commit,
  output logic [7:0]       hold_rdata,
  output logic             irq
);
  localparam int HW = $clog2(HOLD_DEPTH);
  // Timer must span two cycles; holding index is the pointer's low bits
  initial begin
    if (PROG_CYCLES < 2 || PROG_CYCLES > 65535 || HOLD_DEPTH < 2 ||
        HW > 22 || (1 << HW) != HOLD_DEPTH)
      $error("tea_top: unsupported parameter values");
  end

  // Shared clock and reset of the checks at the end of this module
  default clocking cb_chk @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  logic [7:0]  ctrl;
  logic [7:0]  data_reg;
  logic [7:0]  addr_low;
  logic [7:0]  addr_high;
  logic [21:0] tbl_ptr;
  logic [7:0]  table_latch;
  logic [7:0]  hold_mem [HOLD_DEPTH];
  logic        irq_stat;
  logic        irq_mask;
  logic [15:0] timer;
  tea_pkg::tea_state_t state;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        done_pulse;
  logic        wr_start;
  logic        rd_start;
  logic [1:0]  region;
  logic        write_ok;
  logic [7:0]  wbyte;

  assign region   = ctrl[tea_pkg::CTRL_REG_LO +: 2];
  assign write_ok = ctrl[tea_pkg::CTRL_PERMIT];
  assign wbyte    = w_data[7:0];

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  // Capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
    end
  end

  // Write response, error for unmapped offsets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= tea_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr > tea_pkg::OFF_IRQ_MASK || aw_addr[1:0] != 2'h0)
                      ? tea_pkg::RESP_SLVERR : tea_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_ctrl;
  assign wr_ctrl = do_write && w_strb[0] && aw_addr == tea_pkg::OFF_CTRL;
  assign rd_start = wr_ctrl && wbyte[tea_pkg::CTRL_RD] &&
                    state == tea_pkg::ST_IDLE &&
                    wbyte[tea_pkg::CTRL_REG_LO +: 2] != tea_pkg::REG_PROGRAM;
  // write only with permit set
  // Both triggers at once: the read wins outside the program region, so WR is never left stuck
  assign wr_start = wr_ctrl && wbyte[tea_pkg::CTRL_WR] && !rd_start &&
                    state == tea_pkg::ST_IDLE && wbyte[tea_pkg::CTRL_PERMIT];

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  // software sets triggers only; hardware clears them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= tea_pkg::CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl[tea_pkg::CTRL_PERMIT]       <= wbyte[tea_pkg::CTRL_PERMIT];
        if (state == tea_pkg::ST_IDLE)
          ctrl[tea_pkg::CTRL_REG_LO +: 2] <= wbyte[tea_pkg::CTRL_REG_LO +: 2];
      end
      if (rd_start)
        ctrl[tea_pkg::CTRL_RD] <= 1'b1;
      if (wr_start) begin
        ctrl[tea_pkg::CTRL_WR]    <= 1'b1;
        // fault flag set with write trigger
        ctrl[tea_pkg::CTRL_FAULT] <= 1'b1;
      end
      if (done_pulse && state == tea_pkg::ST_READ)
        ctrl[tea_pkg::CTRL_RD] <= 1'b0;
      if (done_pulse && state == tea_pkg::ST_WRITE) begin
        ctrl[tea_pkg::CTRL_WR]    <= 1'b0;
        // fault flag cleared on timer expiry
        ctrl[tea_pkg::CTRL_FAULT] <= 1'b0;
      end
    end
  end

  // Data and address registers, EEPROM read result returns to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_reg  <= 8'h00;
      addr_low  <= 8'h00;
      addr_high <= 8'h00;
    end else begin
      if (do_write && w_strb[0] && state == tea_pkg::ST_IDLE) begin
        if (aw_addr == tea_pkg::OFF_DATA)     data_reg  <= wbyte;
        if (aw_addr == tea_pkg::OFF_ADDR_LOW) addr_low  <= wbyte;
        if (aw_addr == tea_pkg::OFF_ADDR_HI)  addr_high <= wbyte;
      end
      // read byte lands in data register
      if (done_pulse && state == tea_pkg::ST_READ)
        data_reg <= mem_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Operation sequencer and programming timer
  // ---------------------------------------------------------------
  // duration set by internal timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= tea_pkg::ST_IDLE;
      timer <= 16'h0000;
    end else begin
      unique case (state)
        tea_pkg::ST_IDLE: begin
          if (rd_start) begin
            state <= tea_pkg::ST_READ;
            timer <= 16'h0000;
          end else if (wr_start) begin
            state <= tea_pkg::ST_WRITE;
            timer <= 16'(PROG_CYCLES - 1);
          end
        end
        tea_pkg::ST_READ: state <= tea_pkg::ST_IDLE;
        tea_pkg::ST_WRITE: begin
          if (timer == 16'h0000) state <= tea_pkg::ST_IDLE;
          else timer <= timer - 16'h0001;
        end
      endcase
    end
  end
  assign done_pulse = (state == tea_pkg::ST_READ) ||
                      (state == tea_pkg::ST_WRITE && timer == 16'h0000);

  // Array request: one-cycle read, write held for the timer period except in the program region
  // single write request erases then programs
  always_comb begin
    mem_req       = '0;
    mem_req.rd    = state == tea_pkg::ST_READ;
    mem_req.wr    = state == tea_pkg::ST_WRITE && region != tea_pkg::REG_PROGRAM;
    mem_req.region = region;
    mem_req.addr  = {6'h00, addr_high, addr_low};
    mem_req.wdata = data_reg;
  end
  // commit holding registers on permitted program write
  assign prog_commit = done_pulse && state == tea_pkg::ST_WRITE &&
                       region == tea_pkg::REG_PROGRAM;

  // ---------------------------------------------------------------
  // Table fetch and store through the latch
  // ---------------------------------------------------------------
  logic tcmd_wr;
  assign tcmd_wr = do_write && w_strb[0] && aw_addr == tea_pkg::OFF_TBLCMD;
  // pointer is a plain byte address
  assign prog_addr = {tbl_ptr[21:1], 1'b0};

  // fetch exactly one byte; latch is the only path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      table_latch <= 8'h00;
      tbl_ptr     <= 22'h000000;
    end else begin
      if (do_write && w_strb[0] && aw_addr == tea_pkg::OFF_LATCH)
        table_latch <= wbyte;
      if (do_write && aw_addr == tea_pkg::OFF_TBLPTR)
        tbl_ptr <= w_data[21:0];
      if (tcmd_wr && wbyte[tea_pkg::TCMD_FETCH])
        table_latch <= tbl_ptr[0] ? prog_word[15:8] : prog_word[7:0];
    end
  end

  // store goes to holding register only
  always_ff @(posedge aclk) begin
    if (tcmd_wr && wbyte[tea_pkg::TCMD_STORE])
      hold_mem[tbl_ptr[HW-1:0]] <= table_latch;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) hold_rdata <= 8'h00;
    else hold_rdata <= hold_mem[tbl_ptr[HW-1:0]];
  end

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  // done flag set on write end; set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= 1'b0;
      irq_mask <= 1'b0;
    end else begin
      if (do_write && w_strb[0] && aw_addr == tea_pkg::OFF_IRQ_MASK)
        irq_mask <= wbyte[0];
      if (done_pulse && state == tea_pkg::ST_WRITE)
        irq_stat <= 1'b1;
      else if (do_write && w_strb[0] && aw_addr == tea_pkg::OFF_IRQ_STAT
               && wbyte[0])
        irq_stat <= 1'b0;
    end
  end
  assign irq = irq_stat & irq_mask;

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= tea_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= tea_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        tea_pkg::OFF_CTRL:     s_axi_rdata <= {24'h0, ctrl};
        tea_pkg::OFF_DATA:     s_axi_rdata <= {24'h0, data_reg};
        tea_pkg::OFF_ADDR_LOW: s_axi_rdata <= {24'h0, addr_low};
        tea_pkg::OFF_ADDR_HI:  s_axi_rdata <= {24'h0, addr_high};
        tea_pkg::OFF_TBLPTR:   s_axi_rdata <= {10'h0, tbl_ptr};
        tea_pkg::OFF_LATCH:    s_axi_rdata <= {24'h0, table_latch};
        tea_pkg::OFF_TBLCMD:   s_axi_rdata <= 32'h0000_0000;
        tea_pkg::OFF_IRQ_STAT: s_axi_rdata <= {31'h0, irq_stat};
        tea_pkg::OFF_IRQ_MASK: s_axi_rdata <= {31'h0, irq_mask};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= tea_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // array read never aimed at program
  a_read_refused: assert property (
    mem_req.rd |-> region != tea_pkg::REG_PROGRAM)
    else $error("read started on program");
  a_permit_gate: assert property (
    $rose(ctrl[tea_pkg::CTRL_WR]) |-> ctrl[tea_pkg::CTRL_PERMIT])
    else $error("write began without permit");
  a_fault_tracks: assert property (
    ctrl[tea_pkg::CTRL_WR] == ctrl[tea_pkg::CTRL_FAULT])
    else $error("fault flag differs from write trigger");
  a_wr_held: assert property (
    $fell(ctrl[tea_pkg::CTRL_WR]) |-> $past(done_pulse))
    else $error("write trigger cleared early");
  a_rd_clear: assert property (
    rd_start |=> ##1 !ctrl[tea_pkg::CTRL_RD])
    else $error("read trigger not cleared");
  // done flag set at write end
  a_done_flag: assert property (
    (done_pulse && state == tea_pkg::ST_WRITE) |=> irq_stat)
    else $error("done flag not set");
  a_write_time: assert property (
    wr_start |=> ctrl[tea_pkg::CTRL_WR] [*2])
    else $error("write ended too soon");
  a_commit_gate: assert property (
    prog_commit |-> ctrl[tea_pkg::CTRL_WR] && region == tea_pkg::REG_PROGRAM)
    else $error("commit without program write");
endmodule : tea_top

// ===== tb/tea_mem_model.sv
// Behavioural program flash and data EEPROM arrays at the far side
`timescale 1ns/1ps
module tea_mem_model (
  input  wire logic                  aclk,
  input  wire tea_pkg::tea_mem_req_t mem_req,
  input  wire logic [21:0]           prog_addr,
  output logic [7:0]                 mem_rdata,
  output logic [15:0]                prog_word
);
  logic [7:0] ee [0:1023];
  logic [7:0] last_rd;
  logic       wr_q;
  // ----------------------------------------
  // Arrays
  // ----------------------------------------
  // Flash word pattern derived from the word address
  assign prog_word = {prog_addr[8:1] ^ 8'hc3, prog_addr[8:1]};
  // Data valid only in the read cycle, otherwise a toggling pattern
  assign mem_rdata = mem_req.rd ? ee[mem_req.addr[9:0]] : ~last_rd;
  initial begin
    for (int i = 0; i < 1024; i++) ee[i] = 8'h00;
    last_rd = 8'h00;
    wr_q    = 1'b0;
  end
  // erase first cycle, then program until the timer ends
  always @(posedge aclk) begin
    wr_q    <= mem_req.wr;
    last_rd <= mem_req.rd ? ee[mem_req.addr[9:0]] : ~last_rd;
    if (mem_req.wr && mem_req.region == tea_pkg::REG_EEPROM)
      ee[mem_req.addr[9:0]] <= wr_q ? mem_req.wdata : 8'hff;
  end
endmodule : tea_mem_model

// ===== tb/tb_table_and_eeprom_access.sv
// Self-checking bench of the table and EEPROM access block
`timescale 1ns/1ps
module tb_table_and_eeprom_access;
  localparam int PROG = 16;
  typedef struct packed {
    logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;
  } tea_row_t;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, prog_commit, irq;
  logic [7:0] awaddr, araddr, mem_rdata, hold_rdata;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [15:0] prog_word;
  logic [21:0] prog_addr;
  tea_pkg::tea_mem_req_t mem_req, last_w;
  int n_errors, n_checks, cyc, n_wr, n_rd, n_cm, b0, b1;
  tea_row_t rows [7];
  tea_top #(.PROG_CYCLES(PROG)) tea_top_inst (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .prog_word(prog_word),
    .prog_addr(prog_addr), .prog_commit(prog_commit),
    .hold_rdata(hold_rdata), .irq(irq));
  tea_mem_model tea_mem_model_inst (.aclk(aclk), .mem_req(mem_req),
    .prog_addr(prog_addr), .mem_rdata(mem_rdata), .prog_word(prog_word));
  // ----------------------------------------
  // Clock, monitor, timeout
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Count array strobes and keep the last write request
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (aresetn && mem_req.wr) begin n_wr <= n_wr + 1; last_w <= mem_req; end
    if (aresetn && mem_req.rd) n_rd <= n_rd + 1;
    if (aresetn && prog_commit) n_cm <= n_cm + 1;
    if (cyc == 20000) begin n_errors++; final_report(); end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (e !== g) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Write with address and data offered together
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0; w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (!aw_ok && awready) begin aw_ok = 1'b1; awvalid <= 1'b0; end
      if (!w_ok && wready) begin w_ok = 1'b1; wvalid <= 1'b0; end
      if (bvalid) begin r = bresp; bready <= 1'b0; break; end
    end
  endtask : wr32
  task automatic rd32(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin v = rdata; r = rresp; rready <= 1'b0; break; end
    end
  endtask : rd32
  // Poll the control register until both triggers are clear
  task automatic wait_idle();
    for (int i = 0; i < 40; i++) begin
      rd32(tea_pkg::OFF_CTRL);
      if (v[1:0] === 2'b00) break;
    end
  endtask : wait_idle
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0_0000_0000_000f;
    {n_errors, n_checks, cyc, n_wr, n_rd, n_cm} = 192'h0;
    rows[0] = {tea_pkg::OFF_DATA, 32'ha5, 32'ha5, tea_pkg::RESP_OKAY};
    rows[1] = {tea_pkg::OFF_ADDR_LOW, 32'h12, 32'h12, tea_pkg::RESP_OKAY};
    rows[2] = {tea_pkg::OFF_ADDR_HI, 32'h03, 32'h03, tea_pkg::RESP_OKAY};
    rows[3] = {tea_pkg::OFF_TBLPTR, 32'h123, 32'h123, tea_pkg::RESP_OKAY};
    rows[4] = {tea_pkg::OFF_IRQ_MASK, 32'h1, 32'h1, tea_pkg::RESP_OKAY};
    rows[5] = {8'h24, 32'h1, 32'h0, tea_pkg::RESP_SLVERR};
    rows[6] = {8'h06, 32'h1, 32'h0, tea_pkg::RESP_SLVERR};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd32(tea_pkg::OFF_CTRL);
    chk("ctrl reset", {24'h0, tea_pkg::CTRL_RESET}, v);
    chk("irq reset", 32'h0, {31'h0, irq});
    // Register rows: write, read back, response code
    foreach (rows[i]) begin
      wr32(rows[i].a, rows[i].d);
      chk("write resp", {30'h0, rows[i].r}, {30'h0, r});
      rd32(rows[i].a);
      chk("read resp", {30'h0, rows[i].r}, {30'h0, r});
      if (rows[i].r === tea_pkg::RESP_OKAY) chk("readback", rows[i].e, v);
    end
    // Table fetch of an even and an odd byte address
    for (int p = 'h122; p <= 'h123; p++) begin
      wr32(tea_pkg::OFF_TBLPTR, 32'(p));
      wr32(tea_pkg::OFF_TBLCMD, 32'h1);
      rd32(tea_pkg::OFF_LATCH);
      chk("latch", {24'h0, p[0] ? 8'h91 ^ 8'hc3 : 8'h91}, v);
    end
    // Table store lands in the holding register, no commit
    b1 = n_cm;
    wr32(tea_pkg::OFF_LATCH, 32'h3c);
    wr32(tea_pkg::OFF_TBLCMD, 32'h2);
    repeat (2) @(posedge aclk);
    chk("hold byte", 32'h3c, {24'h0, hold_rdata});
    chk("no commit", 32'(b1), 32'(n_cm));
    // EEPROM byte write with permit
    wr32(tea_pkg::OFF_DATA, 32'h77);
    b0 = n_wr;
    wr32(tea_pkg::OFF_CTRL, 32'h06);
    wr32(tea_pkg::OFF_CTRL, 32'h04);
    rd32(tea_pkg::OFF_CTRL);
    chk("busy bits", 32'h3, {30'h0, v[3], v[1]});
    wait_idle();
    chk("fault clear", 32'h0, {31'h0, v[3]});
    chk("write cycles", 32'(PROG), 32'(n_wr - b0));
    chk("write addr", 32'h312, {16'h0, last_w.addr[15:0]});
    chk("write data", 32'h77, {24'h0, last_w.wdata});
    chk("irq on done", 32'h1, {31'h0, irq});
    wr32(tea_pkg::OFF_IRQ_STAT, 32'h1);
    rd32(tea_pkg::OFF_IRQ_STAT);
    chk("done cleared", 32'h0, {31'h0, v[0]});
    chk("irq cleared", 32'h0, {31'h0, irq});
    // Write trigger without permit is refused
    wr32(tea_pkg::OFF_CTRL, 32'h02);
    rd32(tea_pkg::OFF_CTRL);
    chk("no permit", 32'h0, {31'h0, v[1]});
    chk("no permit cyc", 32'(b0 + PROG), 32'(n_wr));
    // Read trigger refused for the program region
    b0 = n_rd;
    wr32(tea_pkg::OFF_CTRL, 32'h81);
    rd32(tea_pkg::OFF_CTRL);
    chk("rd refused", 32'h0, {31'h0, v[0]});
    chk("rd strobes", 32'(b0), 32'(n_rd));
    // EEPROM read brings back the stored byte
    wr32(tea_pkg::OFF_CTRL, 32'h01);
    wait_idle();
    chk("rd strobe", 32'(b0 + 1), 32'(n_rd));
    rd32(tea_pkg::OFF_DATA);
    chk("ee data", 32'h77, v);
    // ID region write carries its region code
    wr32(tea_pkg::OFF_CTRL, 32'h46);
    wait_idle();
    chk("id region", 32'(tea_pkg::REG_ID), 32'(last_w.region));
    // Program region write commits the holding registers once
    wr32(tea_pkg::OFF_CTRL, 32'h86);
    wait_idle();
    chk("commit", 32'(b1 + 1), 32'(n_cm));
    // Both triggers in one write: the read runs, the write is dropped
    wr32(tea_pkg::OFF_CTRL, 32'h07);
    wait_idle();
    chk("both triggers", 32'h0, {30'h0, v[1:0]});
    // Reset in mid-write clears triggers and the permit bit
    wr32(tea_pkg::OFF_CTRL, 32'h06);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd32(tea_pkg::OFF_CTRL);
    chk("ctrl mid reset", {24'h0, tea_pkg::CTRL_RESET}, v);
    final_report();
  end
endmodule : tb_table_and_eeprom_access
